// file: spc_serial_port.v
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.vh"

module spc_serial_port #(
  parameter DIV_W = 12
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output wire        avs_waitrequest,
  output reg  [31:0] avs_readdata,
  // core side
  input  wire        globalIrqEn,
  output wire        txDoneIrq,
  output wire        bufEmptyIrq,
  output wire        rxDoneIrq,
  // line side
  input  wire        rxPin,
  input  wire        xckPin,
  output reg         txPinOut,
  output wire        txPinOe,
  output wire        rxPinClaim
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [2:0] T_IDLE  = 3'h0;
  localparam [2:0] T_START = 3'h1;
  localparam [2:0] T_DATA  = 3'h2;
  localparam [2:0] T_PAR   = 3'h3;
  localparam [2:0] T_STOP1 = 3'h4;
  localparam [2:0] T_STOP2 = 3'h5;
  localparam [2:0] R_IDLE  = 3'h0;
  localparam [2:0] R_START = 3'h1;
  localparam [2:0] R_DATA  = 3'h2;
  localparam [2:0] R_PAR   = 3'h3;
  localparam [2:0] R_STOP  = 3'h4;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function [3:0] charBits;
    input [2:0] csz;
    begin
      case (csz)
        3'h0: charBits = 4'h5;
        3'h1: charBits = 4'h6;
        3'h2: charBits = 4'h7;
        3'h7: charBits = 4'h9;
        // reserved codes behave as eight bits
        default: charBits = 4'h8;
      endcase
    end
  endfunction

  function parityOf;
    input [8:0] data;
    input [3:0] nBits;
    input       odd;
    integer     i;
    reg         acc;
    begin
      acc = odd;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < nBits) begin
          acc = acc ^ data[i];
        end
      end
      parityOf = acc;
    end
  endfunction

  // --------------------------------------------------------------------
  // bus slave: one wait cycle for every access
  // --------------------------------------------------------------------
  reg              ack_r;
  reg  [7:0]       rdMux;
  wire             busReq = avs_read | avs_write;
  wire             wrEn   = avs_write & ack_r & avs_byteenable[0];
  wire             rdEn   = avs_read & ack_r;
  wire [7:0]       wData  = avs_writedata[7:0];

  assign avs_waitrequest = busReq & ~ack_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq & ~ack_r;
    end
  end

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  reg  [7:0]       ctrl_r;
  reg  [7:0]       frame_r;
  reg  [DIV_W-1:0] divisor_r;
  reg              dSpeed_r;
  wire             wrCtrl  = wrEn & (avs_address == `SPC_IDX_CTRL);
  wire             wrFrame = wrEn & (avs_address == `SPC_IDX_FRAME);
  wire             wrHi    = wrEn & (avs_address == `SPC_IDX_BAUD_HI);
  wire             wrLo    = wrEn & (avs_address == `SPC_IDX_BAUD_LO);
  wire             wrStat  = wrEn & (avs_address == `SPC_IDX_STAT);
  wire             wrData  = wrEn & (avs_address == `SPC_IDX_DATA);
  wire             popData = rdEn & (avs_address == `SPC_IDX_DATA);
  // between reloads the prescaler must not follow whatever is on the bus
  wire [DIV_W-1:0] divNew  = wrLo ? {divisor_r[DIV_W-1:8], wData}
                                  : divisor_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r    <= `SPC_CTRL_RST;
      frame_r   <= `SPC_FRAME_RST;
      divisor_r <= `SPC_BAUD_RST;
      dSpeed_r  <= 1'b0;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= wData;
      end
      if (wrFrame) begin
        // upper mode bit stays zero: master spi is not reachable here
        frame_r <= {1'b0, wData[6:0]};
      end
      if (wrHi) begin
        divisor_r[DIV_W-1:8] <= wData[DIV_W-9:0];
      end
      if (wrLo) begin
        divisor_r[7:0] <= wData;
      end
      if (wrStat) begin
        dSpeed_r <= wData[`SPC_STAT_DSPEED];
      end
    end
  end

  wire       receiver_enable     = ctrl_r[`SPC_CTRL_RX_EN];
  wire       txEnReq  = ctrl_r[`SPC_CTRL_TX_EN];
  wire [1:0] opMode   = frame_r[7:6];
  wire [1:0] parMode  = frame_r[5:4];
  wire       syncMode = (opMode == `SPC_MODE_SYNC);
  wire       parOn    = parMode[1];
  wire [3:0] nBits    = charBits({ctrl_r[`SPC_CTRL_CSZ_HI],
                                  frame_r[2:1]});
  // double speed only matters for async timing
  wire [4:0] osLen    = dSpeed_r ? `SPC_OS_DOUBLE : `SPC_OS_NORMAL;
  wire [4:0] osLast   = osLen - 5'h01;
  wire [4:0] osHalf   = {1'b0, osLen[4:1]} - 5'h01;

  // --------------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------------
  wire osTick;

  spc_baud_gen #(
    .DIV_W   (DIV_W)
  ) u_baud (
    .ref_clk (ref_clk),
    .srst    (srst),
    .divisor (divNew),
    .reload  (wrLo),
    .osTick  (osTick)
  );

  // --------------------------------------------------------------------
  // pin synchronisers: a change counts once stages two and three agree
  // --------------------------------------------------------------------
  reg [2:0] rxS_r;
  reg [2:0] xckS_r;
  reg       rxLvl_r;
  reg       xckLvl_r;
  reg       xckPrev_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      rxS_r     <= 3'h7;
      xckS_r    <= 3'h0;
      rxLvl_r   <= 1'b1;
      xckLvl_r  <= 1'b0;
      xckPrev_r <= 1'b0;
    end else begin
      rxS_r  <= {rxS_r[1:0], rxPin};
      xckS_r <= {xckS_r[1:0], xckPin};
      if (rxS_r[1] == rxS_r[2]) begin
        rxLvl_r <= rxS_r[2];
      end
      if (xckS_r[1] == xckS_r[2]) begin
        xckLvl_r <= xckS_r[2];
      end
      xckPrev_r <= xckLvl_r;
    end
  end

  wire xckRise    = xckLvl_r & ~xckPrev_r;
  wire xckFall    = ~xckLvl_r & xckPrev_r;
  wire pol        = frame_r[`SPC_FRM_POL];
  wire changeEdge = pol ? xckFall : xckRise;
  wire sampleEdge = pol ? xckRise : xckFall;

  // --------------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------------
  reg  [2:0] txState_r;
  reg  [8:0] txBuf_r;
  reg        bufFull_r;
  reg  [8:0] txShift_r;
  reg  [3:0] txIdx_r;
  reg  [4:0] txOs_r;
  reg        txPar_r;
  reg        transmitter_enable_r;
  reg        txDone_r;
  reg        txFinish;
  wire       txStep = syncMode ? changeEdge
                               : (osTick & (txOs_r == osLast));

  always @(posedge ref_clk) begin
    if (srst) begin
      txState_r <= T_IDLE;
      txBuf_r   <= 9'h000;
      bufFull_r <= 1'b0;
      txShift_r <= 9'h000;
      txIdx_r   <= 4'h0;
      txOs_r    <= 5'h00;
      txPar_r   <= 1'b0;
      txFinish  <= 1'b0;
    end else begin
      txFinish <= 1'b0;
      // writes while the buffer is occupied are dropped
      if (wrData & ~bufFull_r) begin
        txBuf_r   <= {ctrl_r[`SPC_CTRL_TX_BIT8], wData};
        bufFull_r <= 1'b1;
      end
      if (txState_r != T_IDLE) begin
        if (txStep) begin
          txOs_r <= 5'h00;
        end else if (osTick) begin
          txOs_r <= txOs_r + 5'h01;
        end
      end
      case (txState_r)
        T_IDLE: begin
          if (transmitter_enable_r & bufFull_r) begin
            txShift_r <= txBuf_r;
            txPar_r   <= parityOf(txBuf_r, nBits, parMode[0]);
            bufFull_r <= 1'b0;
            txOs_r    <= 5'h00;
            txState_r <= T_START;
          end
        end
        T_START: begin
          if (txStep) begin
            txIdx_r   <= 4'h0;
            txState_r <= T_DATA;
          end
        end
        T_DATA: begin
          if (txStep) begin
            txShift_r <= {1'b0, txShift_r[8:1]};
            txIdx_r   <= txIdx_r + 4'h1;
            if (txIdx_r == nBits - 4'h1) begin
              txState_r <= parOn ? T_PAR : T_STOP1;
            end
          end
        end
        T_PAR: begin
          if (txStep) begin
            txState_r <= T_STOP1;
          end
        end
        T_STOP1: begin
          if (txStep) begin
            if (frame_r[`SPC_FRM_STOP]) begin
              txState_r <= T_STOP2;
            end else begin
              txState_r <= T_IDLE;
              txFinish  <= 1'b1;
            end
          end
        end
        T_STOP2: begin
          if (txStep) begin
            txState_r <= T_IDLE;
            txFinish  <= 1'b1;
          end
        end
        default: begin
          txState_r <= T_IDLE;
        end
      endcase
    end
  end

  // line level, one cycle behind the state
  always @(posedge ref_clk) begin
    if (srst) begin
      txPinOut <= 1'b1;
    end else begin
      case (txState_r)
        T_START: txPinOut <= 1'b0;
        T_DATA:  txPinOut <= txShift_r[0];
        T_PAR:   txPinOut <= txPar_r;
        default: txPinOut <= 1'b1;
      endcase
    end
  end

  wire txIdle   = (txState_r == T_IDLE) & ~bufFull_r;
  wire txDoneSet = txFinish & ~bufFull_r;
  wire txDoneClr = wrStat & wData[`SPC_STAT_TXDONE];

  always @(posedge ref_clk) begin
    if (srst) begin
      transmitter_enable_r   <= 1'b0;
      txDone_r <= 1'b0;
    end else begin
      if (txEnReq) begin
        transmitter_enable_r <= 1'b1;
      end else if (txIdle) begin
        // disable only bites once nothing is left to send
        transmitter_enable_r <= 1'b0;
      end
      // a frame ending with the buffer empty in the clearing cycle still leaves the flag set
      txDone_r <= txDoneSet | (txDone_r & ~txDoneClr);
    end
  end

  assign txPinOe = transmitter_enable_r;

  // --------------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------------
  reg  [2:0] rxState_r;
  reg  [8:0] rxShift_r;
  reg  [3:0] rxIdx_r;
  reg  [4:0] rxOs_r;
  reg        rxPar_r;
  reg        rxPErr_r;
  reg        rxDone;
  reg        rxFErr;
  reg  [8:0] rxData_r;
  reg        rxFull_r;
  reg        fe_r;
  reg        dor_r;
  reg        upe_r;
  wire       rxSample = syncMode ? sampleEdge
                                 : (osTick & (rxOs_r == osLast));

  always @(posedge ref_clk) begin
    if (srst) begin
      rxState_r <= R_IDLE;
      rxShift_r <= 9'h000;
      rxIdx_r   <= 4'h0;
      rxOs_r    <= 5'h00;
      rxPar_r   <= 1'b0;
      rxPErr_r  <= 1'b0;
      rxDone    <= 1'b0;
      rxFErr    <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      if (osTick) begin
        rxOs_r <= rxOs_r + 5'h01;
      end
      if (rxSample) begin
        rxOs_r <= 5'h00;
      end
      case (rxState_r)
        R_IDLE: begin
          rxOs_r <= 5'h00;
          rxIdx_r <= 4'h0;
          rxPar_r <= 1'b0;
          if (receiver_enable & ~rxLvl_r) begin
            if (~syncMode) begin
              rxState_r <= R_START;
            end else if (sampleEdge) begin
              rxShift_r <= 9'h000;
              rxState_r <= R_DATA;
            end
          end
        end
        R_START: begin
          if (osTick & (rxOs_r == osHalf)) begin
            rxOs_r    <= 5'h00;
            rxShift_r <= 9'h000;
            // a glitch shorter than half a bit is no start
            rxState_r <= rxLvl_r ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rxSample) begin
            rxShift_r[rxIdx_r] <= rxLvl_r;
            rxPar_r <= rxPar_r ^ rxLvl_r;
            rxIdx_r <= rxIdx_r + 4'h1;
            rxPErr_r <= 1'b0;
            if (rxIdx_r == nBits - 4'h1) begin
              rxState_r <= parOn ? R_PAR : R_STOP;
            end
          end
        end
        R_PAR: begin
          if (rxSample) begin
            rxPErr_r  <= (rxPar_r ^ rxLvl_r) != parMode[0];
            rxState_r <= R_STOP;
          end
        end
        R_STOP: begin
          // only the first stop bit is checked
          if (rxSample) begin
            rxFErr    <= ~rxLvl_r;
            rxDone    <= 1'b1;
            rxState_r <= R_IDLE;
          end
        end
        default: begin
          rxState_r <= R_IDLE;
        end
      endcase
      if (~receiver_enable) begin
        rxState_r <= R_IDLE;
      end
    end
  end

  // one-deep buffer; a new frame wins over a read in the same cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      rxData_r <= 9'h000;
      rxFull_r <= 1'b0;
      fe_r     <= 1'b0;
      dor_r    <= 1'b0;
      upe_r    <= 1'b0;
    end else if (~receiver_enable) begin
      rxFull_r <= 1'b0;
      fe_r     <= 1'b0;
      dor_r    <= 1'b0;
      upe_r    <= 1'b0;
    end else if (rxDone) begin
      if (rxFull_r & ~popData) begin
        dor_r <= 1'b1;
      end else begin
        rxData_r <= rxShift_r;
        rxFull_r <= 1'b1;
        fe_r     <= rxFErr;
        dor_r    <= 1'b0;
        upe_r    <= rxPErr_r & parOn;
      end
    end else if (popData) begin
      rxFull_r <= 1'b0;
      fe_r     <= 1'b0;
      dor_r    <= 1'b0;
      upe_r    <= 1'b0;
    end
  end

  assign rxPinClaim = receiver_enable;

  // --------------------------------------------------------------------
  // interrupt requests and read-back
  // --------------------------------------------------------------------
  assign txDoneIrq   = ctrl_r[`SPC_CTRL_TXC_IE] & globalIrqEn
                     & txDone_r;
  assign bufEmptyIrq = ctrl_r[`SPC_CTRL_BUF_IE] & globalIrqEn
                     & ~bufFull_r;
  assign rxDoneIrq   = ctrl_r[`SPC_CTRL_RXC_IE] & globalIrqEn & rxFull_r;

  always @* begin
    rdMux = 8'h00;
    if (avs_address == `SPC_IDX_BAUD_HI) begin
      rdMux = {4'h0, divisor_r[DIV_W-1:8]};
    end else if (avs_address == `SPC_IDX_BAUD_LO) begin
      rdMux = divisor_r[7:0];
    end else if (avs_address == `SPC_IDX_FRAME) begin
      rdMux = frame_r;
    end else if (avs_address == `SPC_IDX_CTRL) begin
      rdMux = {ctrl_r[7:2], rxData_r[8], ctrl_r[0]};
    end else if (avs_address == `SPC_IDX_STAT) begin
      rdMux = {rxFull_r, txDone_r, ~bufFull_r, fe_r, dor_r, upe_r,
               dSpeed_r, 1'b0};
    end else if (avs_address == `SPC_IDX_DATA) begin
      rdMux = rxData_r[7:0];
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (busReq & ~ack_r) begin
      avs_readdata <= {24'h000000, rdMux};
    end
  end

endmodule

`default_nettype wire

// file: spc_regs.vh
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SPC_IDX_BAUD_HI    4'h2
`define SPC_IDX_FRAME      4'h3
`define SPC_IDX_BAUD_LO    4'h9
`define SPC_IDX_CTRL       4'hA
`define SPC_IDX_STAT       4'hB
`define SPC_IDX_DATA       4'hC

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPC_FRAME_RST      8'h06
`define SPC_CTRL_RST       8'h00
`define SPC_BAUD_RST       12'h000

// ----------------------------------------------------------------------
// enable_and_irq_control fields
// ----------------------------------------------------------------------
`define SPC_CTRL_RXC_IE    7
`define SPC_CTRL_TXC_IE    6
`define SPC_CTRL_BUF_IE    5
`define SPC_CTRL_RX_EN     4
`define SPC_CTRL_TX_EN     3
`define SPC_CTRL_CSZ_HI    2
`define SPC_CTRL_RX_BIT8   1
`define SPC_CTRL_TX_BIT8   0

// ----------------------------------------------------------------------
// frame_format_control fields
// ----------------------------------------------------------------------
`define SPC_FRM_MODE_HI    7
`define SPC_FRM_MODE_LO    6
`define SPC_FRM_PAR_HI     5
`define SPC_FRM_PAR_LO     4
`define SPC_FRM_STOP       3
`define SPC_FRM_CSZ_HI     2
`define SPC_FRM_CSZ_LO     1
`define SPC_FRM_POL        0

// ----------------------------------------------------------------------
// status_register_a fields
// ----------------------------------------------------------------------
`define SPC_STAT_RXC       7
`define SPC_STAT_TXDONE    6
`define SPC_STAT_BUFEMPTY  5
`define SPC_STAT_FE        4
`define SPC_STAT_DOR       3
`define SPC_STAT_UPE       2
`define SPC_STAT_DSPEED    1

// ----------------------------------------------------------------------
// modes and timing
// ----------------------------------------------------------------------
`define SPC_MODE_ASYNC     2'h0
`define SPC_MODE_SYNC      2'h1
`define SPC_MODE_SPI       2'h3
`define SPC_PAR_OFF        2'h0
`define SPC_PAR_EVEN       2'h2
`define SPC_PAR_ODD        2'h3
`define SPC_OS_NORMAL      5'h10
`define SPC_OS_DOUBLE      5'h08

`endif

// file: spc_baud_gen.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// prescaler: one tick every divisor+1 clocks
// ----------------------------------------------------------------------
module spc_baud_gen #(
  parameter DIV_W = 12
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // control
  input  wire [DIV_W-1:0] divisor,
  input  wire             reload,
  // tick out
  output reg              osTick
);

  reg [DIV_W-1:0] count_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      count_r <= {DIV_W{1'b0}};
      osTick  <= 1'b0;
    end else if (reload) begin
      // new divisor takes over at once, no wait for the old period
      count_r <= divisor;
      osTick  <= 1'b0;
    end else if (count_r == {DIV_W{1'b0}}) begin
      count_r <= divisor;
      osTick  <= 1'b1;
    end else begin
      count_r <= count_r - {{(DIV_W-1){1'b0}}, 1'b1};
      osTick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: spc_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// remote peer: times and decodes tx, sends rx
// ------------------------------------------------
module spc_peer (
  // line
  input  wire logic ref_clk,
  input  wire logic txLine,
  output var  logic rxLine
);
  int cyc = 0;
  int bitClk = 16;
  initial rxLine = 1'b1;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // one sample per bit at its centre, start time in clocks
  task automatic take(input int n, output logic [11:0] got,
                      output int t0);
    got = 12'h000;
    while (txLine !== 1'b0) @(posedge ref_clk);
    t0 = cyc;
    repeat (bitClk / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (bitClk) @(posedge ref_clk);
      got[i] = txLine;
    end
  endtask
  // start, bits lsb first, then idle mark; any stop bit comes in v
  task automatic send(input logic [11:0] v, input int n);
    rxLine <= 1'b0;
    repeat (bitClk) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxLine <= v[i];
      repeat (bitClk) @(posedge ref_clk);
    end
    rxLine <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: spc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// port checker
// ------------------------------------------------
module spc_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // core and line
  input wire logic        globalIrqEn,
  input wire logic        txDoneIrq,
  input wire logic        bufEmptyIrq,
  input wire logic        txPinOut,
  input wire logic        txPinOe,
  input wire logic        rxPinClaim
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic req = avs_read || avs_write;
  wire logic ctlWr = avs_write && !avs_waitrequest && avs_address == 4'hA;
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait state");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  a_idle_quiet: assert property (!req |-> !avs_waitrequest)
    else $error("wait while idle");
  a_rd_upper: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper data set");
  a_txc_gated: assert property (!globalIrqEn |-> !txDoneIrq)
    else $error("tx done irq ungated");
  a_buf_gated: assert property (!globalIrqEn |-> !bufEmptyIrq)
    else $error("empty irq ungated");
  a_rx_claim: assert property (ctlWr |=>
    rxPinClaim == $past(avs_writedata[4])) else $error("rx claim wrong");
  a_oe_rise: assert property (ctlWr && avs_writedata[3] |->
    ##[1:3] txPinOe) else $error("tx pin not taken");
  a_oe_hold: assert property (txPinOe && !txPinOut |=> txPinOe)
    else $error("tx pin dropped in frame");
  a_release_high: assert property (!txPinOe |-> txPinOut)
    else $error("released pin not idle");
  c_tx_off: cover property (ctlWr && !avs_writedata[3]);
  c_txc_irq: cover property (txDoneIrq);
  c_buf_irq: cover property (bufEmptyIrq);
endmodule
bind spc_serial_port spc_checker chk (
  .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .globalIrqEn(globalIrqEn),
  .txDoneIrq(txDoneIrq), .bufEmptyIrq(bufEmptyIrq), .txPinOut(txPinOut),
  .txPinOe(txPinOe), .rxPinClaim(rxPinClaim));
`default_nettype wire

// file: test_serial_port_control_and_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_serial_port_control_and_baud;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam logic [3:0] IBH = `SPC_IDX_BAUD_HI, IFR = `SPC_IDX_FRAME;
  localparam logic [3:0] IBL = `SPC_IDX_BAUD_LO, ICT = `SPC_IDX_CTRL;
  localparam logic [3:0] IST = `SPC_IDX_STAT, IDA = `SPC_IDX_DATA;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        globalIrqEn = 1'b0;
  logic        ext_serial_clock = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, txDoneIrq, bufEmptyIrq, rxDoneIrq;
  wire         rxPin, txPinOut, txPinOe, rxPinClaim;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 19580;
  int          t1, t2, n, nl, bc;
  logic [7:0]  q, div;
  logic [8:0]  d1, d2;
  logic [11:0] g1, g2, v;
  logic [2:0]  csz;
  logic [1:0]  par;
  logic        stp, ds;
  logic [3:0]  ix [6] = '{IBH, IFR, IBL, ICT, IST, 4'h0};
  logic [7:0]  rv [6] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h20, 8'h00};
  logic [2:0]  cs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0]  pm [3] = '{2'h0, 2'h2, 2'h3};
  spc_serial_port DUT (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .globalIrqEn(globalIrqEn),
    .txDoneIrq(txDoneIrq), .bufEmptyIrq(bufEmptyIrq),
    .rxDoneIrq(rxDoneIrq), .rxPin(rxPin), .xckPin(ext_serial_clock),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinClaim(rxPinClaim));
  spc_peer peer (.ref_clk(ref_clk), .txLine(txPinOut), .rxLine(rxPin));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // master holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q & m, e)
  endtask
  function automatic int bits_of(input logic [2:0] c);
    return (c == 3'h7) ? 9 : int'(c) + 5;
  endfunction
  // data bits, parity if on, one stop; only the bits on the line
  function automatic logic [11:0] frm(input logic [8:0] d, input int k,
                                      input logic [1:0] p);
    logic [11:0] f;
    logic        b;
    f = 12'hFFF;
    b = p[0];
    for (int i = 0; i < k; i++) begin
      f[i] = d[i];
      b ^= d[i];
    end
    if (p[1])
      f[k] = b;
    return f & ((12'h1 << (k + p[1] + 1)) - 12'h1);
  endfunction
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(ix[i], 8'hFF, rv[i]);
    bus(1'b1, IFR, 8'hC6);
    rd(IFR, 8'hFF, 8'h46);
    bus(1'b1, IBH, 8'hF3);
    rd(IBH, 8'hFF, 8'h03);
    bus(1'b1, IBH, 8'h00);
    for (int k = 0; k < 5; k++) begin
      div = 8'($random(seed) & 3);
      csz = cs[k];
      par = pm[k % 3];
      stp = k[0];
      ds = (k == 4);
      n = bits_of(csz);
      nl = n + par[1] + 1;
      bc = (ds ? 8 : 16) * (div + 1);
      peer.bitClk = bc;
      bus(1'b1, IBL, div);
      bus(1'b1, IFR, {2'h0, par, stp, csz[1:0], 1'b0});
      bus(1'b1, IST, {6'h10, ds, 1'b0});
      d1 = 9'($random(seed));
      d2 = {d1[8], 8'($random(seed))};
      bus(1'b1, ICT, {3'h2, 2'h3, csz[2], 1'b0, d1[8]});
      globalIrqEn <= 1'b1;
      fork
        begin
          peer.take(nl, g1, t1);
          peer.take(nl, g2, t2);
        end
        begin
          bus(1'b1, IDA, d1[7:0]);
          bus(1'b1, IDA, d2[7:0]);
        end
      join
      `CHK(txDoneIrq, 1'b0)
      `CHK(g1, frm(d1, n, par))
      `CHK(g2, frm(d2, n, par))
      `CHK((t2 - t1 + bc / 2) / bc, nl + stp + 1)
      while (txDoneIrq !== 1'b1) @(posedge ref_clk);
      globalIrqEn <= 1'b0;
      rd(IST, 8'h40, 8'h40);
      `CHK(txDoneIrq, 1'b0)
      bus(1'b1, IST, {6'h10, ds, 1'b0});
      rd(IST, 8'h40, 8'h00);
    end
    fork
      peer.take(nl, g1, t1);
      begin
        bus(1'b1, IDA, d1[7:0]);
        bus(1'b1, ICT, {5'h02, csz[2], 1'b0, d1[8]});
        @(posedge ref_clk);
        `CHK(txPinOe, 1'b1)
      end
    join
    `CHK(g1, frm(d1, n, par))
    repeat (3 * bc) @(posedge ref_clk);
    `CHK(txPinOe, 1'b0)
    for (int j = 0; j < 3; j++) begin
      d1 = 9'($random(seed));
      v = frm(d1, 9, 2'h2);
      v[9] = v[9] ^ (j != 0);
      @(posedge ref_clk);
      peer.send(v, 11);
      q = 8'h00;
      while (q[7] !== 1'b1)
        bus(1'b0, IST, 8'h00);
      `CHK(q[2], j != 0)
      if (j == 2) begin
        bus(1'b1, ICT, 8'h04);
        rd(IST, 8'h9C, 8'h00);
        `CHK(rxPinClaim, 1'b0)
      end else begin
        rd(ICT, 8'h02, {6'h0, d1[8], 1'b0});
        rd(IDA, 8'hFF, d1[7:0]);
      end
    end
    // synchronous frame, polarity zero: bits move on rising clock
    bus(1'b1, IFR, 8'h46);
    bus(1'b1, ICT, 8'h08);
    bus(1'b1, IDA, d1[7:0]);
    for (int i = 0; i < 10; i++) begin
      ext_serial_clock <= 1'b1;
      repeat (8) @(posedge ref_clk);
      `CHK(txPinOut, (i < 8) ? d1[i] : 1'b1)
      ext_serial_clock <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
    bus(1'b1, ICT, 8'hA4);
    @(posedge ref_clk);
    `CHK(bufEmptyIrq, 1'b0)
    globalIrqEn <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    `CHK(bufEmptyIrq, 1'b1)
    `CHK(rxDoneIrq, 1'b0)
    end_sim();
  end
endmodule
`default_nettype wire
